// ===== dv/pin_load_model.sv
// Far side: drives the timer input pin and loads the channel 4 output.
// Assumes the same ref_clk; pin is a free-running square wave.
`timescale 1ns/1ns
module pin_load_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic timerOut4,
    output logic pinDrive,
    output int toggleCount,
    output int lastGap
);
    int pinDiv; // Half period of the pin, 8 cycles
    int sinceToggle; // Cycles since the last output change
    logic outSeen; // Output level one edge ago
    // Pin toggles every 8 cycles, rising edges 16 apart; gap measured
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pinDiv <= 0;
            pinDrive <= 1'b0;
            outSeen <= 1'b0;
            sinceToggle <= 0;
            toggleCount <= 0;
            lastGap <= 0;
        end else begin
            pinDiv <= (pinDiv == 7) ? 0 : pinDiv + 1;
            if (pinDiv == 7) begin
                pinDrive <= !pinDrive;
            end
            outSeen <= timerOut4;
            sinceToggle <= sinceToggle + 1;
            if (timerOut4 != outSeen) begin
                toggleCount <= toggleCount + 1;
                lastGap <= sinceToggle;
                sinceToggle <= 1;
            end
        end
    end
endmodule

// ===== dv/tb.sv
// Self-checking bench for the timer channel block over APB.
// Assumes the pin load model and the bound checker are compiled.
`timescale 1ns/1ns
`include "timer_defines.svh"
module tb;
    logic ref_clk; // 250 MHz
    logic reset;
    logic psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, pinDrive, timerOut3, timerOut4, irq;
    int toggleCount, lastGap, badCount, samplesChecked;
    logic [31:0] rd; // Last read word
    logic lastErr; // Error flag of the last access
    timer_channel_output_and_mode_config dut_u (.ref_clk, .reset, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .ch4TimerInputPin(pinDrive), .timerOut3,
        .timerOut4, .irq);
    pin_load_model load_u (.ref_clk, .reset, .timerOut4, .pinDrive, .toggleCount, .lastGap);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            badCount++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) badCount++;
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk); // Idle cycle keeps each signal to one change per step
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    // Bounded wait for a level on pin 3
    task automatic wait3(input logic v);
        int n;
        n = 0;
        while (timerOut3 !== v && n < 80) begin
            @(posedge ref_clk);
            n++;
        end
        chk({31'h0, timerOut3}, {31'h0, v});
    endtask
    task automatic t_reset_values();
        for (int a = 0; a <= 48; a += 4) rdchk(8'(a), 32'h0000_0000);
        rdchk(8'h34, 32'h0000_0000); // Unmapped place reads zero
        chk({31'h0, lastErr}, 32'h0000_0001);
    endtask
    // Legal trigger and mode codes read back; only clocks 0 and 1 on this channel
    task automatic t_mode_fields();
        logic [2:0] trig [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
        logic [2:0] mode [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};
        timer_pkg::mode_reg_t m;
        for (int i = 0; i < 5; i++) begin
            m = '0;
            m.prescaleSel = i[0] ? 2'h2 : 2'h0;
            m.countSource = i[1];
            m.leadRole = i[0];
            m.triggerSel = trig[i % 4];
            m.edgeSel = 2'(i);
            m.opMode = mode[i];
            m.startIrqOption = i[1];
            wr(`OFF_CH4_MODE, {16'h0000, m});
            rdchk(`OFF_CH4_MODE, {16'h0000, m});
        end
        // Pin triggers above may leave channel 4 running; park it
        wr(`OFF_CONTROL, 32'h0000_0002);
        wr(`OFF_CH4_DATA, 32'h0000_00C7);
        rdchk(`OFF_CH4_DATA, 32'h0000_00C7);
    endtask
    // Disabled outputs follow software writes; polarity leaves the pin alone
    task automatic t_sw_output();
        wr(`OFF_OUT_VALUE, 32'h0000_0018);
        chk({30'h0, timerOut4, timerOut3}, 32'h0000_0003);
        wr(`OFF_POLARITY, 32'h0000_0018);
        chk({30'h0, timerOut4, timerOut3}, 32'h0000_0003);
        wr(`OFF_OUT_VALUE, 32'h0000_0000);
        chk({30'h0, timerOut4, timerOut3}, 32'h0000_0000);
        wr(`OFF_POLARITY, 32'h0000_0000);
    endtask
    // Toggle spacing of output 4 for clock 0, clock 1 and pin edges
    task automatic t_periods();
        logic [15:0] modes [3] = '{16'h0801, 16'h8801, 16'h1801};
        int gaps [3] = '{8, 16, 64};
        int c, n;
        logic lvl;
        wr(`OFF_PRESCALE, 32'h0000_0021); // Clock 0 every 2 cycles, clock 1 every 4
        wr(`OFF_CH4_DATA, 32'h0000_0003);
        wr(`OFF_OUT_ENABLE, 32'h0000_0010);
        for (int i = 0; i < 3; i++) begin
            wr(`OFF_CH4_MODE, {16'h0000, modes[i]});
            c = toggleCount;
            wr(`OFF_CONTROL, 32'h0000_0001);
            repeat (gaps[i] / 2) @(posedge ref_clk);
            chk(32'(toggleCount - c), 32'h0000_0001);
            n = 0;
            while (toggleCount < c + 4 && n < 400) begin
                @(posedge ref_clk);
                n++;
            end
            chk(32'(lastGap), 32'(gaps[i]));
            if (i < 2) wr(`OFF_CONTROL, 32'h0000_0002);
        end
        c = toggleCount;
        while (toggleCount == c) @(posedge ref_clk);
        lvl = timerOut4;
        wr(`OFF_OUT_VALUE, {27'h0, !lvl, 4'h0});
        chk({31'h0, timerOut4}, {31'h0, lvl});
        rdchk(`OFF_OUT_VALUE, {27'h0, lvl, 4'h0});
        wr(`OFF_CONTROL, 32'h0000_0002);
        wr(`OFF_OUT_ENABLE, 32'h0000_0000);
    endtask
    // Slave output set by the lead channel, reset by its own count
    task automatic t_slave();
        wr(`OFF_CH4_MODE, 32'h0000_0801);
        wr(`OFF_CH4_DATA, 32'h0000_0007);
        wr(`OFF_CH3_DATA, 32'h0000_0001);
        for (int p = 0; p < 2; p++) begin
            wr(`OFF_OUT_ENABLE, 32'h0000_0000);
            wr(`OFF_POLARITY, 32'(p) << 3);
            wr(`OFF_OUT_VALUE, 32'(p) << 3); // Idle at the inactive level
            wr(`OFF_OUT_ENABLE, 32'h0000_0008);
            wr(`OFF_CONTROL, 32'h0000_000D);
            wait3(p == 0);
            wait3(p != 0);
            wr(`OFF_CONTROL, 32'h0000_0002);
        end
    endtask
    // High width of the pin (8 cycles) in clock 0 ticks, counted up from 0
    task automatic t_width();
        wr(`OFF_CH4_MODE, 32'h0000_010C);
        repeat (40) @(posedge ref_clk);
        rdchk(`OFF_CH4_CAPTURE, 32'h0000_0003);
    endtask
    // Sticky status, mask and write-one clear
    task automatic t_irq();
        repeat (8) @(posedge ref_clk);
        wr(`OFF_IRQ_MASK, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        rdchk(`OFF_IRQ_STATUS, 32'h0000_0003);
        wr(`OFF_IRQ_MASK, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(`OFF_IRQ_STATUS, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0000);
        rdchk(`OFF_IRQ_STATUS, 32'h0000_0001);
    endtask
    task automatic finalReport();
        $display("Checks %0d, mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Free-running clock, 4 ns period
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Main sequence
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        badCount = 0;
        samplesChecked = 0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        t_reset_values();
        t_mode_fields();
        t_sw_output();
        t_periods();
        t_slave();
        t_width();
        t_irq();
        finalReport();
    end
    // Watchdog, far beyond the several hundred cycles the run needs
    initial begin
        #80000;
        badCount++;
        finalReport();
    end
endmodule

// ===== dv/timer_chk.sv
// Checker for the timer channel block, bound to its top-level ports.
// Assumes one clock ref_clk and a synchronous active-high reset.
`timescale 1ns/1ns
`include "timer_defines.svh"
module timer_chk (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timerOut3,
    input wire logic timerOut4,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic wrDone; // Access edge that commits a write
    logic [1:0] mask_reg; // Copy of the interrupt mask
    logic [4:3] en_reg; // Copy of the output enables
    assign wrDone = psel && penable && pwrite;
    // Copies follow the write edge, as the registers do
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mask_reg <= 2'h0;
            en_reg <= 2'h0;
        end else if (wrDone && paddr == `OFF_IRQ_MASK) begin
            mask_reg <= pwdata[1:0];
        end else if (wrDone && paddr == `OFF_OUT_ENABLE) begin
            en_reg <= pwdata[4:3];
        end
    end
    // Software write to the output value word
    sequence s_value_wr;
        wrDone && paddr == `OFF_OUT_VALUE;
    endsequence
    a_ready_access: assert property (pready == (psel && penable))
        else $error("pready not tied to the access phase");
    a_slverr_map: assert property (pslverr == (psel && penable && (paddr > 8'h30 || paddr[1:0] != 2'h0)))
        else $error("pslverr does not match the address map");
    a_rdata_hold: assert property (psel && penable && !pwrite |=> $stable(prdata))
        else $error("read data moved before the next read");
    a_reset_quiet: assert property ($fell(reset) |-> !irq && !timerOut3 && !timerOut4)
        else $error("outputs active right after reset");
    a_out3_write: assert property (s_value_wr ##0 !en_reg[3] |=> timerOut3 == $past(pwdata[3]))
        else $error("pin 3 does not follow a written value");
    a_out4_write: assert property (s_value_wr ##0 !en_reg[4] |=> timerOut4 == $past(pwdata[4]))
        else $error("pin 4 does not follow a written value");
    a_irq_has_mask: assert property (irq |-> mask_reg != 2'h0)
        else $error("interrupt raised while fully masked");
    a_irq_mask_off: assert property (wrDone && paddr == `OFF_IRQ_MASK && pwdata[1:0] == 2'h0 |=> !irq[*2])
        else $error("interrupt stays up after masking");
endmodule
bind timer_channel_output_and_mode_config timer_chk chk_u (.ref_clk, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timerOut3, .timerOut4, .irq);

// ===== logic/timer_channel_output_and_mode_config.sv
// Two timer channels: channel 4 (mode register driven, master) and
// channel 3 (one-count slave), with output value/enable control and a slave-mode polarity for output 3.
// Assumes an APB master on ref_clk and a timer input pin from outside.
`timescale 1ns/1ns
`include "timer_defines.svh"
module timer_channel_output_and_mode_config #(
    parameter int CNT_W = 16
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ch4TimerInputPin,
    output logic timerOut3,
    output logic timerOut4,
    output logic irq
);
    // Software registers
    logic [15:0] polarityReg, polarityNext;
    logic [15:0] valueReg, valueNext;
    logic [15:0] enableReg, enableNext;
    timer_pkg::mode_reg_t modeReg, modeNext;
    logic [CNT_W-1:0] data4Reg, data4Next;
    logic [CNT_W-1:0] data3Reg, data3Next;
    logic [3:0] ctlReg, ctlNext;
    logic [15:0] prescaleReg, prescaleNext;
    logic [1:0] irqStatReg, irqStatNext;
    logic [1:0] irqMaskReg, irqMaskNext;
    logic [31:0] prdataReg, prdataNext;
    // Channel 4 state
    timer_pkg::ch_state_t st4Reg, st4Next;
    logic [CNT_W-1:0] cnt4Reg, cnt4Next;
    logic [CNT_W-1:0] cap4Reg, cap4Next;
    logic irq4;
    // Channel 3 state
    timer_pkg::ch_state_t st3Reg, st3Next;
    logic [CNT_W-1:0] cnt3Reg, cnt3Next;
    logic irq3;
    // Prescaler and input path
    logic [15:0] divReg;
    logic [3:0] ckTick;
    logic [2:0] pinSync;
    logic pinLevel, pinPrev;
    // Bus decode
    logic wrStrobe, rdSetup, mapped;
    logic swStart4, swStop4;
    // Decode of a word offset, shared by write and error paths
    function automatic logic isMapped(input logic [7:0] a);
        case (a)
            `OFF_POLARITY, `OFF_OUT_VALUE, `OFF_OUT_ENABLE,
            `OFF_CH4_MODE, `OFF_CH4_DATA, `OFF_CH3_DATA,
            `OFF_CONTROL, `OFF_PRESCALE, `OFF_IRQ_STATUS,
            `OFF_IRQ_MASK, `OFF_CH4_COUNT, `OFF_CH4_CAPTURE,
            `OFF_RUN_STATUS: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction
    // Operating clock pick from the two select bits
    function automatic logic pickClock(input logic [1:0] sel, input logic [3:0] t);
        case (sel)
            2'b00: pickClock = t[0];
            2'b01: pickClock = t[2];
            2'b10: pickClock = t[1];
            default: pickClock = t[3];
        endcase
    endfunction
    assign wrStrobe = psel & penable & pwrite & mapped;
    assign rdSetup = psel & ~penable & ~pwrite;
    assign mapped = isMapped(paddr);
    // Zero wait states; unmapped words answer with an error
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdataReg;
    assign swStart4 = wrStrobe & (paddr == `OFF_CONTROL) & pwdata[`CTL_START4];
    assign swStop4 = wrStrobe & (paddr == `OFF_CONTROL) & pwdata[`CTL_STOP4];
    // Free divider; each prescaled clock is a one-cycle enable of 2^n
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            divReg <= `RST_REG16;
        end else begin
            divReg <= divReg + 16'h0001;
        end
    end
    // Four prescaled enables, each with its own 4-bit power select
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_tick
            logic [15:0] mask;
            assign mask = (16'h0001 << prescaleReg[g*4 +: 4]) - 16'h0001;
            assign ckTick[g] = ((divReg & mask) == mask);
        end
    endgenerate
    // Pin passes three flops; only flops two and three are compared
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pinSync <= 3'h0;
        end else begin
            pinSync <= {pinSync[1:0], ch4TimerInputPin};
        end
    end
    // Channel 4 operating clock, edge detect and count clock
    logic opTick4, pinLevelNext, pinPrevNext;
    logic riseEv, fallEv, validEv, oppEv, pinTrig, cntTick4;
    assign opTick4 = pickClock(modeReg.prescaleSel, ckTick);
    always_comb begin
        // Filtered level only moves once flops two and three agree
        pinLevelNext = (pinSync[2] == pinSync[1]) ? pinSync[2] : pinLevel;
        // Edge detector samples on the operating clock only
        pinPrevNext = opTick4 ? pinLevel : pinPrev;
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pinLevel <= 1'b0;
            pinPrev <= 1'b0;
        end else begin
            pinLevel <= pinLevelNext;
            pinPrev <= pinPrevNext;
        end
    end
    assign riseEv = opTick4 & pinLevel & ~pinPrev;
    assign fallEv = opTick4 & ~pinLevel & pinPrev;
    // Edge select bit 0: 0 rising valid, 1 falling valid
    assign validEv = modeReg.edgeSel[0] ? fallEv : riseEv;
    assign oppEv = modeReg.edgeSel[0] ? riseEv : fallEv;
    // Count clock: operating clock or valid pin edges
    assign cntTick4 = modeReg.countSource ? validEv : opTick4;
    // Pin start/capture trigger per trigger field
    always_comb begin
        case (modeReg.triggerSel)
            timer_pkg::TRIG_VALID_EDGE: pinTrig = validEv;
            timer_pkg::TRIG_BOTH_EDGES: pinTrig = riseEv | fallEv;
            // Master irq source and prohibited codes: no pin trigger;
            // channel 4 has no master above it in this block
            default: pinTrig = 1'b0;
        endcase
    end
    // Channel 4 counter, per counting mode
    always_comb begin
        st4Next = st4Reg;
        cnt4Next = cnt4Reg;
        cap4Next = cap4Reg;
        irq4 = 1'b0;
        case (modeReg.opMode)
            timer_pkg::MODE_INTERVAL, timer_pkg::MODE_EVENT: begin
                // Down count, reload on start and underflow
                if (swStart4 | pinTrig) begin
                    st4Next = timer_pkg::CH_RUN;
                    cnt4Next = data4Reg;
                    // Start irq only in interval mode with option set
                    irq4 = modeReg.startIrqOption &
                        (modeReg.opMode == timer_pkg::MODE_INTERVAL);
                end else if (st4Reg == timer_pkg::CH_RUN && cntTick4) begin
                    if (cnt4Reg == '0) begin
                        cnt4Next = data4Reg;
                        irq4 = 1'b1;
                    end else begin
                        cnt4Next = cnt4Reg - 1'b1;
                    end
                end
            end
            timer_pkg::MODE_ONE_COUNT: begin
                // Retrigger while running only with option set
                if ((swStart4 | pinTrig) &&
                    (st4Reg == timer_pkg::CH_IDLE || modeReg.startIrqOption)) begin
                    st4Next = timer_pkg::CH_RUN;
                    cnt4Next = data4Reg;
                    irq4 = (st4Reg == timer_pkg::CH_RUN);
                end else if (st4Reg == timer_pkg::CH_RUN && cntTick4) begin
                    if (cnt4Reg == '0) begin
                        st4Next = timer_pkg::CH_IDLE;
                        irq4 = 1'b1;
                    end else begin
                        cnt4Next = cnt4Reg - 1'b1;
                    end
                end
            end
            timer_pkg::MODE_CAPTURE: begin
                // First trigger starts; later pin triggers capture and clear
                if (st4Reg == timer_pkg::CH_IDLE && (swStart4 | pinTrig)) begin
                    st4Next = timer_pkg::CH_RUN;
                    cnt4Next = '0;
                    irq4 = modeReg.startIrqOption;
                end else if (st4Reg == timer_pkg::CH_RUN && pinTrig) begin
                    cap4Next = cnt4Reg;
                    cnt4Next = '0;
                    irq4 = 1'b1;
                end else if (st4Reg == timer_pkg::CH_RUN && cntTick4) begin
                    cnt4Next = cnt4Reg + 1'b1;
                end
            end
            timer_pkg::MODE_CAP_ONE: begin
                // Valid edge opens the window, opposite edge closes it
                if (st4Reg == timer_pkg::CH_IDLE && (swStart4 | pinTrig)) begin
                    st4Next = timer_pkg::CH_RUN;
                    cnt4Next = '0;
                end else if (st4Reg == timer_pkg::CH_RUN && oppEv) begin
                    cap4Next = cnt4Reg;
                    st4Next = timer_pkg::CH_IDLE;
                    irq4 = 1'b1;
                end else if (st4Reg == timer_pkg::CH_RUN && cntTick4) begin
                    cnt4Next = cnt4Reg + 1'b1;
                end
            end
            default: begin
                // Prohibited mode codes freeze the channel
                st4Next = st4Reg;
            end
        endcase
        // Stop command has the last word
        if (swStop4) begin
            st4Next = timer_pkg::CH_IDLE;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st4Reg <= timer_pkg::CH_IDLE;
            cnt4Reg <= '0;
            cap4Reg <= '0;
        end else begin
            st4Reg <= st4Next;
            cnt4Reg <= cnt4Next;
            cap4Reg <= cap4Next;
        end
    end
    // Channel 3: one-count slave started by the master irq
    logic slaveTrig3;
    assign slaveTrig3 = ctlReg[`CTL_SLAVE3_EN] & irq4 & modeReg.leadRole;
    always_comb begin
        st3Next = st3Reg;
        cnt3Next = cnt3Reg;
        irq3 = 1'b0;
        if (slaveTrig3) begin
            // Retrigger restarts the delay each master period
            st3Next = timer_pkg::CH_RUN;
            cnt3Next = data3Reg;
        end else if (st3Reg == timer_pkg::CH_RUN && ckTick[0]) begin
            if (cnt3Reg == '0) begin
                st3Next = timer_pkg::CH_IDLE;
                irq3 = 1'b1;
            end else begin
                cnt3Next = cnt3Reg - 1'b1;
            end
        end
        if (!ctlReg[`CTL_SLAVE3_EN]) begin
            st3Next = timer_pkg::CH_IDLE;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st3Reg <= timer_pkg::CH_IDLE;
            cnt3Reg <= '0;
        end else begin
            st3Reg <= st3Next;
            cnt3Reg <= cnt3Next;
        end
    end
    // Register writes, output value control and interrupt status
    logic [31:0] rdMux;
    logic valWrite;
    always_comb begin
        polarityNext = polarityReg;
        enableNext = enableReg;
        modeNext = modeReg;
        data4Next = data4Reg;
        data3Next = data3Reg;
        ctlNext = ctlReg;
        prescaleNext = prescaleReg;
        irqMaskNext = irqMaskReg;
        valWrite = wrStrobe & (paddr == `OFF_OUT_VALUE);
        if (wrStrobe) begin
            case (paddr)
                `OFF_POLARITY: polarityNext = pwdata[15:0];
                `OFF_OUT_ENABLE: enableNext = pwdata[15:0];
                // Reserved mode bits stay zero
                `OFF_CH4_MODE: modeNext = pwdata[15:0] & `MODE_WR_MASK;
                `OFF_CH4_DATA: data4Next = pwdata[CNT_W-1:0];
                `OFF_CH3_DATA: data3Next = pwdata[CNT_W-1:0];
                // Start/stop are self-clearing commands, not stored
                `OFF_CONTROL: ctlNext = {pwdata[3:2], 2'b00};
                `OFF_PRESCALE: prescaleNext = pwdata[15:0];
                `OFF_IRQ_MASK: irqMaskNext = pwdata[1:0];
                default: ctlNext = ctlReg;
            endcase
        end
        // Software writes land only where the timer does not own the bit
        valueNext = valWrite ? ((pwdata[15:0] & ~enableReg) | (valueReg & enableReg))
                             : valueReg;
        // Channel 4 master output toggles on its own irq
        if (enableReg[`OUT4_BIT] && irq4) begin
            valueNext[`OUT4_BIT] = ~valueReg[`OUT4_BIT];
        end
        // Channel 3: slave mode sets on master irq, resets on own irq
        if (enableReg[`OUT3_BIT]) begin
            if (ctlReg[`CTL_SLAVE3_MODE]) begin
                if (irq3) begin
                    valueNext[`OUT3_BIT] = polarityReg[`OUT3_BIT];
                end else if (slaveTrig3) begin
                    valueNext[`OUT3_BIT] = ~polarityReg[`OUT3_BIT];
                end
            end else if (irq3) begin
                valueNext[`OUT3_BIT] = ~valueReg[`OUT3_BIT];
            end
        end
        // Sticky status: a new event beats a same-cycle clear
        irqStatNext = irqStatReg;
        if (wrStrobe && paddr == `OFF_IRQ_STATUS) begin
            irqStatNext = irqStatReg & ~pwdata[1:0];
        end
        irqStatNext[`IRQ_CH4] = irqStatNext[`IRQ_CH4] | irq4;
        irqStatNext[`IRQ_CH3] = irqStatNext[`IRQ_CH3] | irq3;
    end
    // Read mux, latched in the setup phase
    always_comb begin
        rdMux = `RST_WORD;
        case (paddr)
            `OFF_POLARITY: rdMux[15:0] = polarityReg;
            `OFF_OUT_VALUE: rdMux[15:0] = valueReg;
            `OFF_OUT_ENABLE: rdMux[15:0] = enableReg;
            `OFF_CH4_MODE: rdMux[15:0] = modeReg;
            `OFF_CH4_DATA: rdMux[CNT_W-1:0] = data4Reg;
            `OFF_CH3_DATA: rdMux[CNT_W-1:0] = data3Reg;
            `OFF_CONTROL: rdMux[3:0] = ctlReg;
            `OFF_PRESCALE: rdMux[15:0] = prescaleReg;
            `OFF_IRQ_STATUS: rdMux[1:0] = irqStatReg;
            `OFF_IRQ_MASK: rdMux[1:0] = irqMaskReg;
            `OFF_CH4_COUNT: rdMux[CNT_W-1:0] = cnt4Reg;
            `OFF_CH4_CAPTURE: rdMux[CNT_W-1:0] = cap4Reg;
            `OFF_RUN_STATUS: rdMux[1:0] = {st3Reg == timer_pkg::CH_RUN,
                                           st4Reg == timer_pkg::CH_RUN};
            default: rdMux = `RST_WORD;
        endcase
        prdataNext = rdSetup ? rdMux : prdataReg;
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            polarityReg <= `RST_REG16;
            valueReg <= `RST_REG16;
            enableReg <= `RST_REG16;
            modeReg <= `RST_REG16;
            data4Reg <= '0;
            data3Reg <= '0;
            ctlReg <= `RST_CTL;
            prescaleReg <= `RST_REG16;
            irqStatReg <= `RST_IRQ;
            irqMaskReg <= `RST_IRQ;
            prdataReg <= `RST_WORD;
        end else begin
            polarityReg <= polarityNext;
            valueReg <= valueNext;
            enableReg <= enableNext;
            modeReg <= modeNext;
            data4Reg <= data4Next;
            data3Reg <= data3Next;
            ctlReg <= ctlNext;
            prescaleReg <= prescaleNext;
            irqStatReg <= irqStatNext;
            irqMaskReg <= irqMaskNext;
            prdataReg <= prdataNext;
        end
    end
    // Pins follow the value bits directly
    assign timerOut3 = valueReg[`OUT3_BIT];
    assign timerOut4 = valueReg[`OUT4_BIT];
    assign irq = |(irqStatReg & irqMaskReg);
endmodule

// ===== logic/timer_defines.svh
// Register offsets, field positions, reset values and masks of the timer block.
// Included by the timer module, the checker and the bench; definitions only.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
`define OFF_POLARITY 8'h00
`define OFF_OUT_VALUE 8'h04
`define OFF_OUT_ENABLE 8'h08
`define OFF_CH4_MODE 8'h0C
`define OFF_CH4_DATA 8'h10
`define OFF_CH3_DATA 8'h14
`define OFF_CONTROL 8'h18
`define OFF_PRESCALE 8'h1C
`define OFF_IRQ_STATUS 8'h20
`define OFF_IRQ_MASK 8'h24
`define OFF_CH4_COUNT 8'h28
`define OFF_CH4_CAPTURE 8'h2C
`define OFF_RUN_STATUS 8'h30
`define CTL_START4 0
`define CTL_STOP4 1
`define CTL_SLAVE3_EN 2
`define CTL_SLAVE3_MODE 3
`define IRQ_CH4 0
`define IRQ_CH3 1
`define OUT3_BIT 3
`define OUT4_BIT 4
`define MODE_WR_MASK 16'hDFCF
`define RST_REG16 16'h0000
`define RST_CTL 4'h0
`define RST_IRQ 2'h0
`define RST_WORD 32'h0000_0000
`endif

// ===== logic/timer_pkg.sv
// Types shared by the timer channel block: mode register layout and codes.
// Assumes timer_defines.svh sits beside it on the include path.
package timer_pkg;
    // Channel mode register layout, bit 15 first
    typedef struct packed {
        logic [1:0] prescaleSel;
        logic rsv13;
        logic countSource;
        logic leadRole;
        logic [2:0] triggerSel;
        logic [1:0] edgeSel;
        logic [1:0] rsv54;
        logic [2:0] opMode;
        logic startIrqOption;
    } mode_reg_t;
    // Counting modes
    typedef enum logic [2:0] {
        MODE_INTERVAL = 3'h0,
        MODE_CAPTURE = 3'h2,
        MODE_EVENT = 3'h3,
        MODE_ONE_COUNT = 3'h4,
        MODE_CAP_ONE = 3'h6
    } count_mode_t;
    // Start trigger sources
    typedef enum logic [2:0] {
        TRIG_SOFTWARE = 3'h0,
        TRIG_VALID_EDGE = 3'h1,
        TRIG_BOTH_EDGES = 3'h2,
        TRIG_MASTER_IRQ = 3'h4
    } trig_sel_t;
    // Channel run state
    typedef enum logic {
        CH_IDLE = 1'b0,
        CH_RUN = 1'b1
    } ch_state_t;
endpackage
